// ===== mmbd_pkg.sv
// Constants and register map for the memory map and bank decoder
// Overview of operation
// - Program fetch and data access use separate ports, both served every cycle.
// - Program address is a 13-bit counter over an 8K by 14-bit space.
// - Only 4K words of 14 bits are physically stored.
// - Program addresses above the store wrap; only low 12 bits select.
// - Any reset starts execution at program address zero.
// - A taken interrupt loads the program counter with address four.
// - Status bits 6 and 5 select one of four data banks.
// - Each bank spans offsets 00h to 7Fh, 128 bytes.
// - Low offsets are special registers; general RAM starts at offset 20h.
// - Busy special registers answer at the same offset in several banks.
// - Top sixteen offsets of banks 1 to 3 map onto bank 0 70h-7Fh.
// - Data is reached directly by offset or indirectly through the pointer.
// - Reads of unimplemented data locations return zero.
// - The indirect location has no storage; it redirects through the pointer.
// - Upper five counter bits load via the latch; low byte is read/write.
package mmbd_pkg;
  localparam int PC_W = 13;
  localparam int PW_W = 14;
  localparam int PSTORE_AW = 12;
  localparam int DADDR_W = 9;
  localparam int OFS_W = 7;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INT_VEC = 13'h0004;
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_PCL = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_PTR = 7'h04;
  localparam logic [6:0] OFS_PCLATCH = 7'h0A;
  localparam logic [6:0] OFS_INTCTL = 7'h0B;
  localparam logic [6:0] OFS_GPR = 7'h20;
  localparam logic [6:0] OFS_SHARED = 7'h70;
  localparam int STAT_BSH = 6;
  localparam int STAT_BSL = 5;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] WB_ADR_STATUS = 4'h0;
  localparam logic [3:0] WB_ADR_PTR = 4'h1;
  localparam logic [3:0] WB_ADR_PCLATCH = 4'h2;
  localparam logic [3:0] WB_ADR_PC = 4'h3;
  localparam logic [3:0] WB_ADR_PMEM_ADR = 4'h4;
  localparam logic [3:0] WB_ADR_PMEM_DAT = 4'h5;
  localparam logic [3:0] WB_ADR_INTCTL = 4'h6;
endpackage : mmbd_pkg

// ===== mmbd_decoder.sv
// Program and data memory address decoder with core address registers
`timescale 1ns/100ps
module mmbd_decoder
  import mmbd_pkg::*;
#(
  parameter int PSTORE_WORDS = 4096
) (
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core fetch path
  input wire logic fetch_en,
  input wire logic int_take,
  output logic [mmbd_pkg::PC_W-1:0] prog_counter,
  output logic [mmbd_pkg::PW_W-1:0] instr_word,
  // Core data path
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [mmbd_pkg::OFS_W-1:0] data_ofs,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic [mmbd_pkg::DADDR_W-1:0] data_phys_addr,
  output logic [7:0] status_flags
);
  import mmbd_pkg::*;

  localparam int GPR_BYTES = 512;

  logic [13:0] pmem_q [0:PSTORE_WORDS-1];
  logic [7:0] gpr_q [0:GPR_BYTES-1];
  logic [12:0] pc_q;
  logic [7:0] pclatch_q;
  logic [7:0] status_q;
  logic [7:0] ptr_q;
  logic [7:0] intctl_q;
  logic [11:0] pmem_adr_q;
  logic [13:0] instr_q;
  logic [7:0] rdata_q;
  logic ack_q;
  logic [31:0] wb_dat_q;

  logic wb_req;
  logic wb_wr;
  logic [3:0] wb_reg;
  logic [8:0] dir_addr;
  logic [8:0] eff_addr;
  logic [6:0] eff_ofs;
  logic [8:0] store_addr;
  logic sfr_pcl;
  logic sfr_stat;
  logic sfr_ptr;
  logic sfr_pclat;
  logic sfr_int;
  logic is_gpr;
  logic is_ind;
  logic ind_null;
  logic core_wr;
  logic gpr_we;
  logic wb_wr_status;
  logic wb_wr_ptr;
  logic wb_wr_pclatch;
  logic wb_wr_pc;
  logic wb_wr_padr;
  logic wb_wr_pdat;
  logic wb_wr_intctl;
  logic [12:0] pc_d;
  logic [11:0] fetch_adr;
  logic [11:0] pmem_adr_d;
  logic [7:0] status_d;
  logic [7:0] ptr_d;
  logic [7:0] pclatch_d;
  logic [7:0] intctl_d;
  logic [7:0] rdata_d;
  logic [31:0] wb_dat_d;

  // New request: the answer comes one cycle later
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  // A write lands at the edge where the master samples the acknowledge
  assign wb_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  assign wb_reg = wb_adr_i[5:2];

  // One write strobe per register on the bus side
  assign wb_wr_status = wb_wr && (wb_reg == WB_ADR_STATUS);
  assign wb_wr_ptr = wb_wr && (wb_reg == WB_ADR_PTR);
  assign wb_wr_pclatch = wb_wr && (wb_reg == WB_ADR_PCLATCH);
  assign wb_wr_pc = wb_wr && (wb_reg == WB_ADR_PC);
  assign wb_wr_padr = wb_wr && (wb_reg == WB_ADR_PMEM_ADR);
  assign wb_wr_pdat = wb_wr && (wb_reg == WB_ADR_PMEM_DAT);
  assign wb_wr_intctl = wb_wr && (wb_reg == WB_ADR_INTCTL);

  // Bank select above the instruction offset
  assign dir_addr = {status_q[STAT_BSH], status_q[STAT_BSL], data_ofs};
  assign is_ind = (data_ofs == OFS_INDIRECT);
  // Indirect through a zero pointer lands on itself: no storage there
  assign ind_null = is_ind && (ptr_q == 8'h00);
  assign core_wr = data_wr && !ind_null;
  // Indirect access uses the pointer with the indirect-bank bit
  assign eff_addr = is_ind ? {status_q[7], ptr_q} : dir_addr;
  assign eff_ofs = eff_addr[6:0];

  // Shared registers decode at the same offset in every bank
  assign sfr_pcl = (eff_ofs == OFS_PCL);
  assign sfr_stat = (eff_ofs == OFS_STATUS);
  assign sfr_ptr = (eff_ofs == OFS_PTR);
  assign sfr_pclat = (eff_ofs == OFS_PCLATCH);
  assign sfr_int = (eff_ofs == OFS_INTCTL);
  assign is_gpr = (eff_ofs >= OFS_GPR);
  // Top sixteen locations of every bank fold onto bank 0
  assign store_addr = (eff_ofs >= OFS_SHARED) ? {2'b00, eff_ofs} : eff_addr;

  assign data_phys_addr = store_addr;
  assign prog_counter = pc_q;
  assign instr_word = instr_q;
  assign data_rdata = rdata_q;
  assign status_flags = status_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = wb_dat_q;

  // Next program counter: interrupt, core low-byte write, bus load, step
  always_comb begin
    pc_d = pc_q;
    if (int_take) begin
      pc_d = INT_VEC;
    end else if (core_wr && sfr_pcl) begin
      pc_d = {pclatch_q[4:0], data_wdata};
    end else if (wb_wr_pc) begin
      pc_d = wb_dat_i[12:0];
    end else if (fetch_en) begin
      pc_d = pc_q + 13'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= RESET_VEC;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Only the low address bits reach the store, so high addresses wrap
  assign fetch_adr = pc_q[PSTORE_AW-1:0];

  // Instruction fetch, independent of the data port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instr_q <= 14'h0000;
    end else if (fetch_en) begin
      instr_q <= pmem_q[fetch_adr];
    end
  end

  // Program store loader
  always_ff @(posedge mclk) begin
    if (wb_wr_pdat) begin
      pmem_q[pmem_adr_q] <= wb_dat_i[13:0];
    end
  end

  // Load address steps after each data word
  always_comb begin
    pmem_adr_d = pmem_adr_q;
    if (wb_wr_padr) begin
      pmem_adr_d = wb_dat_i[11:0];
    end else if (wb_wr_pdat) begin
      pmem_adr_d = pmem_adr_q + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pmem_adr_q <= 12'h000;
    end else begin
      pmem_adr_q <= pmem_adr_d;
    end
  end

  // Core status: bits 4:3 cannot be written by the core
  always_comb begin
    status_d = status_q;
    if (core_wr && sfr_stat) begin
      status_d = {data_wdata[7:5], status_q[4:3], data_wdata[2:0]};
    end else if (wb_wr_status) begin
      status_d = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // Indirect address pointer
  always_comb begin
    ptr_d = ptr_q;
    if (core_wr && sfr_ptr) begin
      ptr_d = data_wdata;
    end else if (wb_wr_ptr) begin
      ptr_d = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= BYTE_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Upper counter latch keeps five bits
  always_comb begin
    pclatch_d = pclatch_q;
    if (core_wr && sfr_pclat) begin
      pclatch_d = {3'b000, data_wdata[4:0]};
    end else if (wb_wr_pclatch) begin
      pclatch_d = {3'b000, wb_dat_i[4:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pclatch_q <= BYTE_RST;
    end else begin
      pclatch_q <= pclatch_d;
    end
  end

  // Interrupt control
  always_comb begin
    intctl_d = intctl_q;
    if (core_wr && sfr_int) begin
      intctl_d = data_wdata;
    end else if (wb_wr_intctl) begin
      intctl_d = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intctl_q <= BYTE_RST;
    end else begin
      intctl_q <= intctl_d;
    end
  end

  // General purpose RAM, one physical byte per folded address
  assign gpr_we = core_wr && is_gpr;

  always_ff @(posedge mclk) begin
    if (gpr_we) begin
      gpr_q[store_addr] <= data_wdata;
    end
  end

  // Data read; indirect through itself and unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    if (ind_null) begin
      rdata_d = 8'h00;
    end else if (is_gpr) begin
      rdata_d = gpr_q[store_addr];
    end else if (sfr_pcl) begin
      rdata_d = pc_q[7:0];
    end else if (sfr_stat) begin
      rdata_d = status_q;
    end else if (sfr_ptr) begin
      rdata_d = ptr_q;
    end else if (sfr_pclat) begin
      rdata_d = pclatch_q;
    end else if (sfr_int) begin
      rdata_d = intctl_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (data_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Bus read multiplexer; unmapped indices read zero
  always_comb begin
    wb_dat_d = 32'h0000_0000;
    unique case (wb_reg)
      WB_ADR_STATUS: wb_dat_d = {24'h000000, status_q};
      WB_ADR_PTR: wb_dat_d = {24'h000000, ptr_q};
      WB_ADR_PCLATCH: wb_dat_d = {24'h000000, pclatch_q};
      WB_ADR_PC: wb_dat_d = {19'h00000, pc_q};
      WB_ADR_PMEM_ADR: wb_dat_d = {20'h00000, pmem_adr_q};
      WB_ADR_PMEM_DAT: wb_dat_d = {18'h00000, pmem_q[pmem_adr_q]};
      WB_ADR_INTCTL: wb_dat_d = {24'h000000, intctl_q};
      default: wb_dat_d = 32'h0000_0000;
    endcase
  end

  // Wishbone answer one cycle after the strobe, dropped the next cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  // Read data is captured when the request is taken and stands with ack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_q <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_q <= wb_dat_d;
    end
  end
endmodule : mmbd_decoder

// ===== mmbd_decoder_assertions.sv
// Port checks for the decoder
`timescale 1ns/100ps
module mmbd_chk
  import mmbd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic fetch_en,
  input wire logic int_take,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [6:0] data_ofs,
  input wire logic [7:0] data_rdata,
  input wire logic [8:0] data_phys_addr,
  input wire logic [12:0] prog_counter,
  input wire logic [7:0] status_flags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_reset_vec: assert property ($rose(rst_n) |-> prog_counter == RESET_VEC)
    else $error("pc not at reset vector");
  chk_int_vec: assert property (int_take |=> prog_counter == INT_VEC)
    else $error("pc not at interrupt vector");
  chk_fetch_step: assert property (fetch_en && !int_take && !data_wr && !wb_cyc_i
    |=> prog_counter == $past(prog_counter) + 13'h1) else $error("pc did not step");
  chk_bank_join: assert property (data_ofs < OFS_GPR && data_ofs != OFS_INDIRECT
    |-> data_phys_addr == {status_flags[6:5], data_ofs}) else $error("bad bank join");
  chk_ram_bank: assert property (data_ofs inside {[7'h20:7'h6F]}
    |-> data_phys_addr == {status_flags[6:5], data_ofs}) else $error("bad ram address");
  chk_shared_fold: assert property (data_ofs >= OFS_SHARED
    |-> data_phys_addr == {2'b00, data_ofs}) else $error("top offsets not folded");
  chk_zero_read: assert property (data_rd && !data_wr
    && data_ofs inside {7'h01, [7'h05:7'h09], [7'h0C:7'h1F]}
    |=> data_rdata == 8'h00) else $error("unimplemented read not zero");
  chk_status_mirror: assert property (data_rd && !data_wr && data_ofs == OFS_STATUS
    |=> data_rdata == $past(status_flags)) else $error("status read mismatch");
endmodule : mmbd_chk
bind mmbd_decoder mmbd_chk u_chk (.mclk, .rst_n, .wb_cyc_i, .fetch_en, .int_take, .data_rd,
  .data_wr, .data_ofs, .data_rdata, .data_phys_addr, .prog_counter, .status_flags);

// ===== mmbd_core_model.sv
// Core fetch and data path driver
`timescale 1ns/100ps
module mmbd_core_model (
  input wire logic mclk,
  output logic fetch_en,
  output logic int_take,
  output logic data_rd,
  output logic data_wr,
  output logic [6:0] data_ofs,
  output logic [7:0] data_wdata
);
  initial begin
    {fetch_en, int_take, data_rd, data_wr, data_ofs, data_wdata} = '0;
  end
  // One core cycle; offset stays held afterwards
  task automatic xfer(input logic r, w, f, i, input logic [6:0] o, input logic [7:0] d);
    @(posedge mclk);
    {data_rd, data_wr, fetch_en, int_take} <= {r, w, f, i};
    data_ofs <= o;
    data_wdata <= d;
    @(posedge mclk);
    {data_rd, data_wr, fetch_en, int_take} <= 4'h0;
  endtask : xfer
endmodule : mmbd_core_model

// ===== tb.sv
// Testbench for the decoder
`timescale 1ns/100ps
module tb;
  import mmbd_pkg::*;
  logic mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic fetch_en, int_take, data_rd, data_wr;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_q;
  logic [12:0] prog_counter;
  logic [13:0] instr_word;
  logic [6:0] data_ofs;
  logic [7:0] data_wdata, data_rdata, status_flags;
  logic [8:0] data_phys_addr;
  int error_cnt, comparisons;
  mmbd_decoder dut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .fetch_en, .int_take, .prog_counter, .instr_word,
    .data_rd, .data_wr, .data_ofs, .data_wdata, .data_rdata, .data_phys_addr, .status_flags);
  mmbd_core_model core (.mclk, .fetch_en, .int_take, .data_rd, .data_wr, .data_ofs,
    .data_wdata);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wb(input logic [3:0] i, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    rd_q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    wb(0, 0, 0); check(rd_q, {24'h0, STATUS_RST});
    wb(3, 0, 0); check(rd_q, 32'h0);
    wb(7, 0, 0); check(rd_q, 32'h0);
    for (int b = 0; b < 4; b++) begin
      wb(0, 1, {1'b0, b[1:0], 5'h18});
      core.xfer(0, 1, 0, 0, 7'h20, 8'hA0 + b[7:0]);
      #1 check(data_phys_addr, {b[1:0], 7'h20});
    end
    for (int b = 0; b < 4; b++) begin
      wb(0, 1, {1'b0, b[1:0], 5'h18});
      core.xfer(1, 0, 0, 0, 7'h20, 0);
      #1 check(data_rdata, 8'hA0 + b);
    end
    core.xfer(0, 1, 0, 0, 7'h75, 8'h5A);
    core.xfer(1, 0, 0, 0, OFS_STATUS, 0);
    #1 check(data_rdata, 8'h78);
    wb(0, 1, 32'h18);
    core.xfer(1, 0, 0, 0, 7'h75, 0);
    #1 check(data_rdata, 8'h5A);
    core.xfer(1, 0, 0, 0, 7'h01, 0);
    #1 check(data_rdata, 0);
    wb(1, 1, 32'h30);
    core.xfer(0, 1, 0, 0, OFS_INDIRECT, 8'hC3);
    core.xfer(1, 0, 0, 0, 7'h30, 0);
    #1 check(data_rdata, 8'hC3);
    wb(2, 1, 32'h01);
    core.xfer(0, 1, 0, 0, OFS_PCL, 8'h22);
    #1 check(prog_counter, 13'h0122);
    wb(4, 1, 0);
    wb(5, 1, 32'h1234);
    wb(4, 1, 4);
    wb(5, 1, 32'h0ABC);
    wb(3, 1, 32'h1000);
    core.xfer(0, 0, 1, 0, 0, 0);
    #1 check(instr_word, 14'h1234);
    check(prog_counter, 13'h1001);
    core.xfer(0, 0, 0, 1, 0, 0);
    #1 check(prog_counter, INT_VEC);
    core.xfer(0, 0, 1, 0, 0, 0);
    #1 check(instr_word, 14'h0ABC);
    @(posedge mclk);
    rst_n <= 1'b0;
    #1 check(prog_counter, RESET_VEC);
    @(posedge mclk);
    rst_n <= 1'b1;
    report_and_stop();
  end
endmodule : tb
